// *** core/cvc_pkg.sv ***
/*
 * Shared constants for the converter control register block: the register
 * offset, field positions, reset value and pulse timing.
 * Assumes a 25 MHz core clock and a 7-bit register address.
 */
package cvc_pkg;

	// ==========================================================
	// Register map
	localparam logic [6:0]  CVC_CTRL0_ADDR   = 7'h4c;
	localparam logic [15:0] CVC_CTRL0_RESET  = 16'h2000;
	localparam int          CVC_BIT_MODE     = 13;
	localparam int          CVC_BIT_TRIG     = 12;
	localparam int          CVC_BIT_LOAD     = 11;
	localparam int          CVC_BIT_REF      = 10;
	localparam int          CVC_BIT_ALARM    = 9;
	localparam logic        CVC_MODE_RESET   = 1'b1;

	// ==========================================================
	// Sizes
	localparam int CVC_ADC_CHANS = 16;
	localparam int CVC_DAC_CHANS = 12;
	localparam int CVC_DAC_BITS  = 12;

	// ==========================================================
	// Timing
	localparam int CVC_CLK_MHZ      = 25;
	localparam int CVC_DAV_PULSE_NS = 1000;
	localparam int CVC_DAV_PULSE_CYC = (CVC_DAV_PULSE_NS * CVC_CLK_MHZ + 999) / 1000;
	localparam logic [5:0] CVC_DAV_CNT_LOAD = 6'(CVC_DAV_PULSE_CYC);

	typedef enum logic [1:0] {
		CVC_SEQ_IDLE,
		CVC_SEQ_START,
		CVC_SEQ_WAIT
	} cvc_seq_state_t;

	// First enabled channel at or above the given index; bit 4 of the result is high if none.
	function automatic logic [4:0] cvc_next_chan(input logic [15:0] en, input logic [4:0] from);
		logic [4:0] res;
		res = 5'h10;
		for (int i = CVC_ADC_CHANS - 1; i >= 0; i--) begin
			if (en[i] && (5'(i) >= from)) begin
				res = 5'(i);
			end
		end
		return res;
	endfunction

endpackage

// *** core/cvc_adc_seq.sv ***
/*
 * ADC channel sequencer: walks the enabled channels once or repeatedly,
 * keeps the conversion-done flag and drives the data-available pin.
 * Assumes the converter answers each start with a one-cycle done pulse.
 */
`timescale 1ns/1ns
module cvc_adc_seq
	import cvc_pkg::*;
(
	input  wire logic        core_clk_i,       // Core clock.
	input  wire logic        sys_rst_i,        // Async reset, active high.
	input  wire logic        repeat_i,         // Continuous mode select.
	input  wire logic        go_i,             // Pending software trigger.
	input  wire logic [15:0] chan_en_i,        // Enabled input channels.
	input  wire logic        conv_done_i,      // Converter finished a channel.
	input  wire logic        flag_clr_i,       // Clear request for done flag.
	output logic             accept_o,         // Trigger taken, pulse.
	output logic             conv_start_o,     // Start one conversion, pulse.
	output logic [3:0]       conv_chan_o,      // Channel to convert.
	output logic             done_flag_o,      // Conversion-done flag.
	output logic             dav_n_o           // Data-available pin, active low.
);

	// ==========================================================
	// Sequencing
	cvc_seq_state_t state_q;
	logic [5:0]     pulse_q;
	logic [4:0]     first_c;
	logic [4:0]     next_c;
	logic           pass_end_c;
	logic           set_flag_c;
	logic           set_pulse_c;

	always_comb begin
		first_c     = cvc_next_chan(chan_en_i, 5'h00);
		next_c      = cvc_next_chan(chan_en_i, 5'({1'b0, conv_chan_o}) + 5'h01);
		pass_end_c  = (state_q == CVC_SEQ_WAIT) && conv_done_i && next_c[4];
		set_flag_c  = pass_end_c && !repeat_i;
		set_pulse_c = pass_end_c && repeat_i;
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q      <= CVC_SEQ_IDLE;
			conv_chan_o  <= 4'h0;
			conv_start_o <= 1'b0;
			accept_o     <= 1'b0;
		end else begin
			conv_start_o <= 1'b0;
			accept_o     <= 1'b0;
			case (state_q)
				CVC_SEQ_IDLE: begin
					if (go_i) begin
						accept_o <= 1'b1;
						if (!first_c[4]) begin
							conv_chan_o <= first_c[3:0];
							state_q     <= CVC_SEQ_START;
						end
					end
				end
				CVC_SEQ_START: begin
					conv_start_o <= 1'b1;
					state_q      <= CVC_SEQ_WAIT;
				end
				CVC_SEQ_WAIT: begin
					if (conv_done_i) begin
						if (!next_c[4]) begin
							conv_chan_o <= next_c[3:0];
							state_q     <= CVC_SEQ_START;
						end else if (repeat_i && !first_c[4]) begin
							conv_chan_o <= first_c[3:0];
							state_q     <= CVC_SEQ_START;
						end else begin
							state_q <= CVC_SEQ_IDLE;
						end
					end
				end
				default: begin
					state_q <= CVC_SEQ_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Done flag and pin
	// A new pass clears the flag, but a pass that ends in the same cycle wins.
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			done_flag_o <= 1'b0;
		end else if (set_flag_c) begin
			done_flag_o <= 1'b1;
		end else if (flag_clr_i || repeat_i || accept_o) begin
			done_flag_o <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pulse_q <= 6'h00;
		end else if (set_pulse_c) begin
			pulse_q <= CVC_DAV_CNT_LOAD;
		end else if (pulse_q != 6'h00) begin
			pulse_q <= pulse_q - 6'h01;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dav_n_o <= 1'b1;
		end else begin
			dav_n_o <= !(set_flag_c || (done_flag_o && !flag_clr_i && !repeat_i && !accept_o)
				|| set_pulse_c || (pulse_q > 6'h01));
		end
	end

endmodule

// *** core/cvc_dac_bank.sv ***
/*
 * DAC latch bank: holds the code each DAC output shows and applies
 * asynchronous or synchronous updates.
 * Assumes data_wr_i pulses in the cycle the matching data value is valid.
 */
`timescale 1ns/1ns
module cvc_dac_bank
	import cvc_pkg::*;
(
	input  wire logic        core_clk_i,                  // Core clock.
	input  wire logic        sys_rst_i,                   // Async reset, active high.
	input  wire logic [11:0] data_i [CVC_DAC_CHANS],      // DAC data registers.
	input  wire logic [11:0] data_wr_i,                   // Data register written, pulse.
	input  wire logic [11:0] sync_sel_i,                  // Synchronous update select.
	input  wire logic        load_i,                      // Synchronous load strobe.
	output logic      [11:0] latch_o [CVC_DAC_CHANS]      // Latched output codes.
);

	// ==========================================================
	// Pending writes and latches
	logic [11:0] pend_q;

	// A write landing with the load still pends for the next strobe.
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pend_q <= 12'h000;
		end else begin
			pend_q <= data_wr_i | (pend_q & ~(load_i ? sync_sel_i : 12'h000));
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < CVC_DAC_CHANS; i++) begin
				latch_o[i] <= 12'h000;
			end
		end else begin
			for (int i = 0; i < CVC_DAC_CHANS; i++) begin
				if (sync_sel_i[i]) begin
					if (load_i && pend_q[i]) begin
						latch_o[i] <= data_i[i];
					end
				end else if (data_wr_i[i]) begin
					latch_o[i] <= data_i[i];
				end
			end
		end
	end

endmodule

// *** core/cvc_top.sv ***
/*
 * Converter control register, bits 13 to 9, with the ADC sequencer and DAC
 * latch bank that it steers.
 * Assumes the serial port front end presents decoded single-cycle register
 * reads and writes on the reg_* ports, synchronous to core_clk_i.
 */
`timescale 1ns/1ns
module cvc_top
	import cvc_pkg::*;
(
	input  wire logic        core_clk_i,                       // Core clock, 25 MHz.
	input  wire logic        sys_rst_i,                        // Async reset, active high.
	input  wire logic        reg_wr_i,                         // Register write, pulse.
	input  wire logic        reg_rd_i,                         // Register read, pulse.
	input  wire logic [6:0]  reg_addr_i,                       // Register address.
	input  wire logic [15:0] reg_wdata_i,                      // Write data.
	output logic      [15:0] reg_rdata_o,                      // Read data, held.
	input  wire logic [15:0] adc_chan_en_i,                    // Enabled ADC channels.
	input  wire logic        adc_conv_done_i,                  // Converter done, pulse.
	input  wire logic        done_flag_clr_i,                  // Flag clear, pulse.
	output logic             adc_conv_start_o,                 // Start conversion, pulse.
	output logic      [3:0]  adc_conv_chan_o,                  // Channel to convert.
	output logic             conversion_done_flag_o,           // Done flag.
	output logic             data_available_pin_n_o,           // Data available, low active.
	input  wire logic [11:0] dac_data_i [CVC_DAC_CHANS],       // DAC data registers.
	input  wire logic [11:0] dac_data_wr_i,                    // DAC data written, pulse.
	input  wire logic [11:0] dac_sync_update_select_i,         // Per-channel sync select.
	output logic      [11:0] dac_latch_o [CVC_DAC_CHANS],      // DAC output codes.
	output logic             adc_ref_internal_o,               // Internal reference on.
	output logic             alarm_pin_enable_o                // Alarm pin enabled.
);

	// ==========================================================
	// Control register
	logic conversion_repeat_select_q;
	logic soft_convert_trigger_q;
	logic sync_dac_load_strobe_q;
	logic adc_ref_int_q;
	logic alarm_en_q;
	logic ctrl_wr_c;
	logic accept_c;

	assign ctrl_wr_c = reg_wr_i && (reg_addr_i == CVC_CTRL0_ADDR);

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			conversion_repeat_select_q <= CVC_MODE_RESET;
			adc_ref_int_q              <= 1'b0;
			alarm_en_q                 <= 1'b0;
		end else if (ctrl_wr_c) begin
			conversion_repeat_select_q <= reg_wdata_i[CVC_BIT_MODE];
			adc_ref_int_q              <= reg_wdata_i[CVC_BIT_REF];
			alarm_en_q                 <= reg_wdata_i[CVC_BIT_ALARM];
		end
	end

	// A fresh write of one wins over the self-clear in the same cycle.
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			soft_convert_trigger_q <= 1'b0;
		end else if (ctrl_wr_c && reg_wdata_i[CVC_BIT_TRIG]) begin
			soft_convert_trigger_q <= 1'b1;
		end else if (accept_c) begin
			soft_convert_trigger_q <= 1'b0;
		end
	end

	// The strobe lives one cycle: that cycle loads the latches.
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync_dac_load_strobe_q <= 1'b0;
		end else if (ctrl_wr_c && reg_wdata_i[CVC_BIT_LOAD]) begin
			sync_dac_load_strobe_q <= 1'b1;
		end else begin
			sync_dac_load_strobe_q <= 1'b0;
		end
	end

	// ==========================================================
	// Read back and pin outputs
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= 16'h0000;
			if (reg_addr_i == CVC_CTRL0_ADDR) begin
				reg_rdata_o[CVC_BIT_MODE]  <= conversion_repeat_select_q;
				reg_rdata_o[CVC_BIT_TRIG]  <= soft_convert_trigger_q;
				reg_rdata_o[CVC_BIT_LOAD]  <= sync_dac_load_strobe_q;
				reg_rdata_o[CVC_BIT_REF]   <= adc_ref_int_q;
				reg_rdata_o[CVC_BIT_ALARM] <= alarm_en_q;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			adc_ref_internal_o <= 1'b0;
			alarm_pin_enable_o <= 1'b0;
		end else begin
			adc_ref_internal_o <= adc_ref_int_q;
			alarm_pin_enable_o <= alarm_en_q;
		end
	end

	// ==========================================================
	// Sub-blocks
	cvc_adc_seq u_seq (
		.core_clk_i   (core_clk_i),
		.sys_rst_i    (sys_rst_i),
		.repeat_i     (conversion_repeat_select_q),
		.go_i         (soft_convert_trigger_q),
		.chan_en_i    (adc_chan_en_i),
		.conv_done_i  (adc_conv_done_i),
		.flag_clr_i   (done_flag_clr_i),
		.accept_o     (accept_c),
		.conv_start_o (adc_conv_start_o),
		.conv_chan_o  (adc_conv_chan_o),
		.done_flag_o  (conversion_done_flag_o),
		.dav_n_o      (data_available_pin_n_o)
	);

	cvc_dac_bank u_dac (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.data_i     (dac_data_i),
		.data_wr_i  (dac_data_wr_i),
		.sync_sel_i (dac_sync_update_select_i),
		.load_i     (sync_dac_load_strobe_q),
		.latch_o    (dac_latch_o)
	);

endmodule

// *** tb/cvc_conv_model.sv ***
/*
 * Converter model: answers each start with one done pulse lat_i + 1 cycles later.
 * Assumes start pulses last one cycle and come one at a time.
 */
`timescale 1ns/1ns
module cvc_conv_model (
	input  wire logic       core_clk_i, // Core clock.
	input  wire logic       sys_rst_i,  // Async reset.
	input  wire logic       start_i,    // Start, pulse.
	input  wire logic [7:0] lat_i,      // Answer delay.
	output logic            done_o      // Done, pulse.
);
	// ==========================================================
	// Converter
	logic [7:0] cnt_q;
	logic       busy_q;

	// Driven on the falling edge, like every other input of the block.
	always @(negedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			done_o <= 1'b0;
			busy_q <= 1'b0;
			cnt_q  <= 8'h00;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				busy_q <= 1'b1;
				cnt_q  <= lat_i;
			end else if (busy_q && cnt_q == 8'h00) begin
				done_o <= 1'b1;
				busy_q <= 1'b0;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule

// *** tb/cvc_top_monitor.sv ***
/*
 * Concurrent checks on the converter control block ports.
 * Assumes one clock domain and the write timing of the register port.
 */
`timescale 1ns/1ns
module cvc_top_monitor
	import cvc_pkg::*;
(
	input wire logic        core_clk_i,                  // Clock.
	input wire logic        sys_rst_i,                   // Reset.
	input wire logic        reg_wr_i,                    // Write.
	input wire logic [6:0]  reg_addr_i,                  // Address.
	input wire logic [15:0] reg_wdata_i,                 // Write data.
	input wire logic [15:0] reg_rdata_o,                 // Read data.
	input wire logic        adc_conv_done_i,             // Converter done.
	input wire logic        adc_conv_start_o,            // Start.
	input wire logic        conversion_done_flag_o,      // Done flag.
	input wire logic        data_available_pin_n_o,      // Data pin.
	input wire logic [11:0] dac_data_wr_i,               // Data written.
	input wire logic [11:0] dac_sync_update_select_i,    // Sync select.
	input wire logic [11:0] dac_latch_o [CVC_DAC_CHANS], // Latches.
	input wire logic        adc_ref_internal_o,          // Reference.
	input wire logic        alarm_pin_enable_o           // Alarm enable.
);
	// ==========================================================
	// Checks
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	// Counts low cycles of the pin so the pulse width needs no long repetition.
	logic [5:0] low_cnt_q;
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			low_cnt_q <= 6'h00;
		end else if (data_available_pin_n_o) begin
			low_cnt_q <= 6'h00;
		end else begin
			low_cnt_q <= low_cnt_q + 6'h01;
		end
	end

	sequence ctl_wr_s;
		reg_wr_i && reg_addr_i == CVC_CTRL0_ADDR;
	endsequence
	sequence mid_pass_s;
		adc_conv_done_i ##1 !conversion_done_flag_o;
	endsequence

	rsvd_zero_a: assert property (reg_rdata_o[15:14] == 2'b00)
		else $error("reserved bits read nonzero");
	ref_follow_a: assert property (ctl_wr_s |=> ##1
		adc_ref_internal_o == $past(reg_wdata_i[CVC_BIT_REF], 2)) else $error("reference wrong");
	alarm_follow_a: assert property (ctl_wr_s |=> ##1
		alarm_pin_enable_o == $past(reg_wdata_i[CVC_BIT_ALARM], 2)) else $error("alarm wrong");
	pulse_len_a: assert property ($rose(data_available_pin_n_o) &&
		!$past(conversion_done_flag_o) |-> low_cnt_q == 6'(CVC_DAV_PULSE_CYC))
		else $error("pulse width wrong");
	flag_pin_a: assert property (conversion_done_flag_o |-> !data_available_pin_n_o)
		else $error("pin not low with flag");
	next_start_a: assert property (mid_pass_s |=> adc_conv_start_o)
		else $error("next start missing");
	start_once_a: assert property (adc_conv_start_o |=> !adc_conv_start_o)
		else $error("start too long");
	sync_load_a: assert property ($changed(dac_latch_o[0]) &&
		$past(dac_sync_update_select_i[0]) |-> $past(reg_wr_i, 2) &&
		$past(reg_addr_i, 2) == CVC_CTRL0_ADDR && $past(reg_wdata_i[CVC_BIT_LOAD], 2))
		else $error("sync latch changed without load");
	async_load_a: assert property ($changed(dac_latch_o[5]) &&
		!$past(dac_sync_update_select_i[5]) |-> $past(dac_data_wr_i[5]))
		else $error("async latch timing wrong");
endmodule

bind cvc_top cvc_top_monitor mon_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
	.reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .adc_conv_done_i(adc_conv_done_i),
	.adc_conv_start_o(adc_conv_start_o), .conversion_done_flag_o(conversion_done_flag_o),
	.data_available_pin_n_o(data_available_pin_n_o), .dac_data_wr_i(dac_data_wr_i),
	.dac_sync_update_select_i(dac_sync_update_select_i), .dac_latch_o(dac_latch_o),
	.adc_ref_internal_o(adc_ref_internal_o), .alarm_pin_enable_o(alarm_pin_enable_o));

// *** tb/cvc_top_test.sv ***
/*
 * Self-checking bench for the converter control block.
 * Assumes the converter model answers starts; inputs change on falling edges.
 */
`timescale 1ns/1ns
module cvc_top_test;
	import cvc_pkg::*;
	// ==========================================================
	// Signals
	logic        clk, rst, wr, rd, clr, done, start, flag, dav_n, refi, alm;
	logic [6:0]  addr;
	logic [15:0] wd, rdat, en, v;
	logic [11:0] dd [CVC_DAC_CHANS];
	logic [11:0] lat [CVC_DAC_CHANS];
	logic [11:0] dwr, sel;
	logic [3:0]  chan;
	logic [7:0]  clat;
	int          error_cnt, num_checks;

	cvc_top dut_u (.core_clk_i(clk), .sys_rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .adc_chan_en_i(en),
		.adc_conv_done_i(done), .done_flag_clr_i(clr), .adc_conv_start_o(start),
		.adc_conv_chan_o(chan), .conversion_done_flag_o(flag),
		.data_available_pin_n_o(dav_n), .dac_data_i(dd), .dac_data_wr_i(dwr),
		.dac_sync_update_select_i(sel), .dac_latch_o(lat), .adc_ref_internal_o(refi),
		.alarm_pin_enable_o(alm));
	cvc_conv_model conv_u (.core_clk_i(clk), .sys_rst_i(rst), .start_i(start),
		.lat_i(clat), .done_o(done));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ==========================================================
	// Tasks
	task automatic summarize;
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wd = d;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [6:0] a);
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		@(negedge clk);
		v = rdat;
	endtask
	// Waits for a start or for the pin to reach lvl; a hang ends the run.
	task automatic wait_for(input bit pin, input logic lvl);
		int i;
		for (i = 0; i < 200 && (pin ? dav_n !== lvl : start !== 1'b1); i++) begin
			@(negedge clk);
		end
		if (i == 200) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, pin ? dav_n : start, pin ? lvl : 1'b1);
			summarize();
		end
	endtask
	task automatic next_start(input logic [3:0] exp);
		wait_for(1'b0, 1'b1);
		check({12'h000, chan}, {12'h000, exp});
		@(negedge clk);
	endtask
	task automatic pulse_clr;
		@(negedge clk);
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		@(negedge clk);
		check({14'h0, flag, dav_n}, 16'h0001);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_fields;
		rd_reg(CVC_CTRL0_ADDR);
		check(v, CVC_CTRL0_RESET);
		check({14'h0, refi, alm}, 16'h0000);
		wr_reg(CVC_CTRL0_ADDR, 16'hc600);
		rd_reg(CVC_CTRL0_ADDR);
		check(v, 16'h0600);
		check({14'h0, refi, alm}, 16'h0003);
		rd_reg(7'h4b);
		check(v, 16'h0000);
	endtask
	task automatic t_single;
		logic [15:0] n;
		en = 16'h8005;
		clat = 8'h03;
		wr_reg(CVC_CTRL0_ADDR, 16'h1600);
		next_start(4'h0);
		next_start(4'h2);
		next_start(4'hf);
		wait_for(1'b1, 1'b0);
		check({15'h0, flag}, 16'h0001);
		n = 16'h0000;
		repeat (20) begin
			@(negedge clk);
			n = n + {15'h0, start};
		end
		check(n, 16'h0000);
		rd_reg(CVC_CTRL0_ADDR);
		check(v, 16'h0600);
		pulse_clr();
	endtask
	task automatic t_cont;
		en = 16'h0012;
		clat = 8'h14;
		wr_reg(CVC_CTRL0_ADDR, 16'h3000);
		next_start(4'h1);
		next_start(4'h4);
		wait_for(1'b1, 1'b0);
		check({15'h0, flag}, 16'h0000);
		next_start(4'h1);
		wr_reg(CVC_CTRL0_ADDR, 16'h0000);
		next_start(4'h4);
		wait_for(1'b1, 1'b1);
		wait_for(1'b1, 1'b0);
		check({15'h0, flag}, 16'h0001);
		pulse_clr();
	endtask
	task automatic t_dac;
		sel = 12'h00f;
		dd[0] = 12'h123;
		dd[1] = 12'h777;
		dd[5] = 12'h456;
		@(negedge clk);
		dwr = 12'h021;
		@(negedge clk);
		dwr = 12'h000;
		@(negedge clk);
		check({4'h0, lat[5]}, 16'h0456);
		check({4'h0, lat[0]}, 16'h0000);
		wr_reg(CVC_CTRL0_ADDR, 16'h0000);
		repeat (3) @(negedge clk);
		check({4'h0, lat[0]}, 16'h0000);
		wr_reg(CVC_CTRL0_ADDR, 16'h0800);
		repeat (2) @(negedge clk);
		check({4'h0, lat[0]}, 16'h0123);
		check({4'h0, lat[1]}, 16'h0000);
		rd_reg(CVC_CTRL0_ADDR);
		check(v, 16'h0000);
	endtask

	initial begin
		rst = 1'b1;
		{wr, rd, clr, addr, wd, en, dwr, sel, clat} = '0;
		foreach (dd[i]) dd[i] = 12'h000;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		t_fields();
		t_single();
		t_cont();
		t_dac();
		summarize();
	end
endmodule
